// [core/sync_terminal_router.sv]
// Sync terminal router: checks and applies source/destination connections between the
// shared sync bus and the card's internal terminals, and drives the routed signals.
// Assumes an APB master, synchronous pin inputs and one 125 MHz clock.
//
// Functional notes
// - Each accepted request joins one source terminal to one destination terminal.
// - Each request yields a signed status: zero ok, negative error, positive warning.
// - Releasing a port's last handle drops every connection of that port.
// - Generation one allows line-to-resync/start, resync-to-line/start, start event-to-line.
// - Generation two adds timebase, star, 20 MHz export, receive and transceiver events.
// - USB variant allows line-to-start, clock line-to-timebase, timebase export, start event out.
// - Generation one chassis card refuses sync line six.
// - Generation one high-speed card: at most four input and four output lines.
// - Generation one card with low-speed port: two input, three output lines.
// - Generation two transceiver event: port 0 even lines, port 1 odd lines.
// - Generation two desktop card refuses star trigger and backplane 10 MHz clock.
// - Generation two PC-card refuses 20 MHz timebase and both backplane terminals.
// - Generation two PC-card refuses sync lines four, five and six.
// - USB variant refuses sync lines one through six.
// - USB variant exports a 1 MHz timebase yet accepts an incoming 20 MHz one.
// - Connected start trigger fires on the first rising edge of its source.
// - Connected resync realigns the timebase on every rising edge of its source.
// - Receive event is a one-bit pulse during the last end-of-frame bit.
// - With nothing routed to master timebase, the local oscillator is used.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module sync_terminal_router
#(
  parameter logic [23:0] RESYNC_HALF_CYC = sync_router_pkg::RESYNC_HALF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [sync_router_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sync bus lines 0..6 and clock line 7
  input wire logic [sync_router_pkg::NUM_LINES-1:0] sync_line_i,
  output logic [sync_router_pkg::NUM_LINES-1:0] sync_line_o,
  output logic [sync_router_pkg::NUM_LINES-1:0] sync_line_oe_o,
  // Backplane terminals
  input wire logic star_trigger_connector_pin_i,
  input wire logic clk10_i,
  // Per-port controller and transceiver side
  input wire logic [sync_router_pkg::NUM_PORTS-1:0] comm_begin_i,
  input wire logic [sync_router_pkg::NUM_PORTS-1:0] rx_accept_i,
  input wire logic [sync_router_pkg::NUM_PORTS-1:0] eof_last_bit_i,
  input wire logic [sync_router_pkg::NUM_PORTS-1:0] xcvr_fault_n_i,
  // Internal terminal outputs
  output logic [sync_router_pkg::NUM_PORTS-1:0] start_fire_o,
  output logic [sync_router_pkg::NUM_PORTS-1:0] rx_event_o,
  output logic resync_align_o,
  output logic [1:0] timebase_sel_o,
  output logic timebase_out_o
);
  import sync_router_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] status;
    logic [1:0] gen;
    logic [1:0] ff;
    logic low_speed;
    logic [NUM_LINES-1:0] line_out;
    logic [NUM_LINES-1:0] line_oe;
    logic [NUM_PORTS-1:0] start_prev;
    logic [NUM_PORTS-1:0] start_fired;
    logic [NUM_PORTS-1:0] start_fire;
    logic resync_prev;
    logic resync_align;
    logic [1:0] tb_sel;
    logic [NUM_PORTS-1:0] rx_event;
    logic [6:0] tb_cnt;
    logic tb_clk;
    logic [23:0] rs_cnt;
    logic rs_clk;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  logic [NUM_LINES-1:0] p_out_en [NUM_PORTS];
  logic [NUM_LINES*SEL_W-1:0] p_out_src [NUM_PORTS];
  logic [NUM_LINES-1:0] p_in_mask [NUM_PORTS];
  logic [NUM_DST-1:0] p_dst_en [NUM_PORTS];
  logic [NUM_DST*SEL_W-1:0] p_dst_src [NUM_PORTS];

  // Value of a source terminal as seen by a given port
  function automatic logic src_val(input logic [3:0] s, input int p);
    logic v;
    v = 1'b0;
    if (s <= TERM_CLK_LINE) begin
      v = sync_line_i[s[2:0]];
    end else begin
      case (s)
        SRC_STAR: v = star_trigger_connector_pin_i;
        SRC_CLK10: v = clk10_i;
        SRC_TB20: v = cur_ff.tb_clk;
        SRC_RESYNC: v = cur_ff.rs_clk;
        SRC_RX_EVT: v = cur_ff.rx_event[p];
        SRC_XCVR_EVT: v = xcvr_fault_n_i[p];
        SRC_START_EVT: v = cur_ff.start_fired[p];
        default: v = 1'b0;
      endcase
    end
    return v;
  endfunction

  // Matrix and availability check for one request; first failure decides the status
  function automatic logic [31:0] check_req(input logic [3:0] src, input logic [3:0] dst, input logic port,
                                            input logic [NUM_LINES-1:0] own_out, input logic [NUM_LINES-1:0] oth_out,
                                            input logic [NUM_DST-1:0] own_dst);
    logic s_gp, d_gp, s_ln, d_ln, ok, gone;
    logic [NUM_LINES-1:0] in_used, out_used;
    int lim_in, lim_out;
    s_gp = src <= LAST_GP_LINE;
    d_gp = dst <= LAST_GP_LINE;
    s_ln = src <= TERM_CLK_LINE;
    d_ln = dst <= TERM_CLK_LINE;
    in_used = p_in_mask[0] | p_in_mask[1];
    out_used = p_out_en[0] | p_out_en[1];
    lim_in = cur_ff.low_speed ? LS_IN_MAX : HS_IN_MAX;
    lim_out = cur_ff.low_speed ? LS_OUT_MAX : HS_OUT_MAX;
    ok = 1'b0;
    gone = 1'b0;
    case (cur_ff.gen)
      GEN_1: begin
        ok = (s_gp && (dst == DST_RESYNC || dst == DST_START)) ||
             (src == SRC_RESYNC && (d_gp || dst == DST_START)) || (src == SRC_START_EVT && d_gp);
        gone = cur_ff.ff == FF_CHASSIS && (src == LAST_GP_LINE || dst == LAST_GP_LINE);
      end
      GEN_2: begin
        ok = (s_gp && (dst == DST_RESYNC || dst == DST_START)) ||
             (src == SRC_RESYNC && (d_gp || dst == DST_START)) || (src == SRC_START_EVT && d_gp) ||
             ((src == TERM_CLK_LINE || src == SRC_CLK10) && dst == DST_MASTER_TB) ||
             (src == SRC_STAR && dst == DST_START) || (src == SRC_TB20 && dst == TERM_CLK_LINE) ||
             (src == SRC_RX_EVT && (d_gp || dst == DST_START)) || (src == SRC_XCVR_EVT && d_gp);
        if (src == SRC_XCVR_EVT && dst[0] != port) begin
          ok = 1'b0;
        end
        if (cur_ff.ff == FF_DESKTOP) begin
          gone = src == SRC_STAR || src == SRC_CLK10;
        end else if (cur_ff.ff == FF_PCCARD) begin
          gone = src == SRC_STAR || src == SRC_CLK10 || src == SRC_TB20 ||
                 (s_gp && src >= PCCARD_FIRST_GONE) || (d_gp && dst >= PCCARD_FIRST_GONE);
        end
      end
      GEN_USB: begin
        ok = (s_gp && dst == DST_START) || (src == TERM_CLK_LINE && dst == DST_MASTER_TB) ||
             (src == SRC_TB20 && dst == TERM_CLK_LINE) || (src == SRC_START_EVT && d_gp);
        gone = (s_gp && src != 4'h0) || (d_gp && dst != 4'h0);
      end
      default: ok = 1'b0;
    endcase
    if (!ok) begin
      return ST_ERR_PAIR;
    end
    if (gone) begin
      return ST_ERR_UNAVAIL;
    end
    if (d_ln && oth_out[dst[2:0]]) begin
      return ST_ERR_BUSY;
    end
    if (cur_ff.gen == GEN_1 && s_ln && !in_used[src[2:0]] && $countones(in_used) >= lim_in) begin
      return ST_ERR_LIMIT;
    end
    if (cur_ff.gen == GEN_1 && d_ln && !out_used[dst[2:0]] && $countones(out_used) >= lim_out) begin
      return ST_ERR_LIMIT;
    end
    if ((d_ln && own_out[dst[2:0]]) || (!d_ln && own_dst[dst[1:0]])) begin
      return ST_WARN_REPLACED;
    end
    return ST_OK;
  endfunction

  // APB decode and request path; the check is a process so config and table changes wake it
  logic setup_w;
  logic wr_w;
  logic req_wr_w;
  logic [3:0] req_src_w;
  logic [3:0] req_dst_w;
  logic req_port_w;
  logic [31:0] chk_w;
  logic [NUM_PORTS-1:0] conn_w;
  logic [NUM_PORTS-1:0] clear_w;

  assign setup_w = psel_i && !penable_i;
  assign wr_w = psel_i && penable_i && cur_ff.pready && pwrite_i;
  assign req_wr_w = wr_w && paddr_i == OFF_REQ;
  assign req_src_w = pwdata_i[REQ_SRC_LSB +: SEL_W];
  assign req_dst_w = pwdata_i[REQ_DST_LSB +: SEL_W];
  assign req_port_w = pwdata_i[REQ_PORT_BIT];
  always_comb chk_w = check_req(req_src_w, req_dst_w, req_port_w, p_out_en[req_port_w], p_out_en[!req_port_w],
                                p_dst_en[req_port_w]);

  // A refused request never reaches a table, so routing stays as it was
  generate
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
      assign conn_w[g] = req_wr_w && !chk_w[31] && req_port_w == g;
      assign clear_w[g] = wr_w && paddr_i == OFF_RELEASE && pwdata_i[g];
      port_route_table #(
        .NL(NUM_LINES),
        .SW(SEL_W),
        .ND(NUM_DST)
      ) u_table (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .conn_i(conn_w[g]),
        .clear_i(clear_w[g]),
        .src_i(req_src_w),
        .dst_i(req_dst_w),
        .out_en_o(p_out_en[g]),
        .out_src_o(p_out_src[g]),
        .in_mask_o(p_in_mask[g]),
        .dst_en_o(p_dst_en[g]),
        .dst_src_o(p_dst_src[g])
      );
    end
  endgenerate

  // Next state: bus slave, timebase dividers, line drivers and trigger terminals
  always_comb begin
    logic [3:0] s;
    logic v;
    logic [6:0] half;
    int own;
    s = 4'h0;
    v = 1'b0;
    half = (cur_ff.gen == GEN_USB) ? TB1M_HALF : TB20_HALF;
    own = 0;
    nxt_ff = cur_ff;
    // Zero wait states: read data is latched at setup, answer stands in the access cycle
    nxt_ff.pready = setup_w;
    nxt_ff.pslverr = 1'b0;
    nxt_ff.prdata = '0;
    if (setup_w) begin
      case (paddr_i)
        OFF_REQ, OFF_RELEASE: nxt_ff.prdata = '0;
        OFF_STATUS: nxt_ff.prdata = cur_ff.status;
        OFF_CFG: nxt_ff.prdata = 32'({cur_ff.low_speed, cur_ff.ff, cur_ff.gen});
        OFF_ROUTE0: nxt_ff.prdata = 32'({p_dst_en[0], p_in_mask[0], p_out_en[0]});
        OFF_ROUTE1: nxt_ff.prdata = 32'({p_dst_en[1], p_in_mask[1], p_out_en[1]});
        OFF_EVENT: nxt_ff.prdata = 32'({cur_ff.tb_sel, cur_ff.start_fired});
        default: nxt_ff.pslverr = 1'b1;
      endcase
    end
    if (wr_w && paddr_i == OFF_CFG) begin
      nxt_ff.gen = pwdata_i[CFG_GEN_LSB +: 2];
      nxt_ff.ff = pwdata_i[CFG_FF_LSB +: 2];
      nxt_ff.low_speed = pwdata_i[CFG_LS_BIT];
    end
    if (req_wr_w) begin
      nxt_ff.status = chk_w;
    end
    // Exported timebase; the half period is floored to whole cycles at this clock rate
    if (cur_ff.tb_cnt >= half - 7'h01) begin
      nxt_ff.tb_cnt = '0;
      nxt_ff.tb_clk = !cur_ff.tb_clk;
    end else begin
      nxt_ff.tb_cnt = cur_ff.tb_cnt + 7'h01;
    end
    if (cur_ff.rs_cnt >= RESYNC_HALF_CYC - 24'h000001) begin
      nxt_ff.rs_cnt = '0;
      nxt_ff.rs_clk = !cur_ff.rs_clk;
    end else begin
      nxt_ff.rs_cnt = cur_ff.rs_cnt + 24'h000001;
    end
    // Line drivers; a line has at most one owning port
    for (int l = 0; l < NUM_LINES; l++) begin
      own = p_out_en[0][l] ? 0 : 1;
      s = p_out_src[own][l*SEL_W +: SEL_W];
      nxt_ff.line_out[l] = src_val(s, own);
      nxt_ff.line_oe[l] = p_out_en[0][l] | p_out_en[1][l];
    end
    // Start trigger fires once on the first rising edge; unrouted it follows comm start
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (p_dst_en[p][DIDX_START]) begin
        v = src_val(p_dst_src[p][DIDX_START*SEL_W +: SEL_W], p);
      end else begin
        v = comm_begin_i[p];
      end
      nxt_ff.start_prev[p] = v;
      nxt_ff.start_fire[p] = v && !cur_ff.start_prev[p] && !cur_ff.start_fired[p];
      if (clear_w[p]) begin
        nxt_ff.start_fired[p] = 1'b0;
      end
      if (nxt_ff.start_fire[p]) begin
        nxt_ff.start_fired[p] = 1'b1; // A trigger in the release cycle still counts
      end
      nxt_ff.rx_event[p] = rx_accept_i[p] && eof_last_bit_i[p];
    end
    // Resync is card-wide; port zero's connection takes precedence
    own = p_dst_en[0][DIDX_RESYNC] ? 0 : 1;
    v = src_val(p_dst_src[own][DIDX_RESYNC*SEL_W +: SEL_W], own);
    nxt_ff.resync_prev = v;
    nxt_ff.resync_align = p_dst_en[own][DIDX_RESYNC] && v && !cur_ff.resync_prev;
    // Master timebase choice, local oscillator when unrouted
    nxt_ff.tb_sel = TB_LOCAL;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (p_dst_en[p][DIDX_MASTER]) begin
        s = p_dst_src[p][DIDX_MASTER*SEL_W +: SEL_W];
        nxt_ff.tb_sel = (s == SRC_CLK10) ? TB_CLK10 : TB_CLK_LINE;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
      cur_ff.gen <= CFG_GEN_RST;
      cur_ff.ff <= CFG_FF_RST;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign prdata_o = cur_ff.prdata;
  assign pready_o = cur_ff.pready;
  assign pslverr_o = cur_ff.pslverr;
  assign sync_line_o = cur_ff.line_out;
  assign sync_line_oe_o = cur_ff.line_oe;
  assign start_fire_o = cur_ff.start_fire;
  assign rx_event_o = cur_ff.rx_event;
  assign resync_align_o = cur_ff.resync_align;
  assign timebase_sel_o = cur_ff.tb_sel;
  assign timebase_out_o = cur_ff.tb_clk;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_release0;
    clear_w[0] && !clear_w[1];
  endsequence

  a_bad_pair_refused: assert property (req_wr_w && chk_w == ST_ERR_PAIR |-> !conn_w[0] && !conn_w[1]
    ##1 $stable(p_out_en[0]) && $stable(p_out_en[1]) && cur_ff.status[31]) else $error("bad pair accepted");
  a_line6_chassis: assert property (req_wr_w && cur_ff.gen == GEN_1 && cur_ff.ff == FF_CHASSIS &&
    (req_src_w == LAST_GP_LINE || req_dst_w == LAST_GP_LINE) |=> cur_ff.status[31]) else $error("line six used");
  a_usb_lines_refused: assert property (req_wr_w && cur_ff.gen == GEN_USB && req_dst_w != 4'h0 &&
    req_dst_w <= LAST_GP_LINE |=> cur_ff.status[31]) else $error("usb line accepted");
  a_connect_one_line: assert property (conn_w[0] && req_dst_w <= TERM_CLK_LINE |=>
    p_out_en[0][$past(req_dst_w[2:0])] ##1 sync_line_oe_o[$past(req_dst_w[2:0], 2)]) else $error("line not routed");
  a_release_drops: assert property (clear_w[0] |=> p_out_en[0] == '0 && p_dst_en[0] == '0 ##1
    sync_line_oe_o == p_out_en[1]) else $error("release left routes");
  a_other_port_kept: assert property (s_release0 |=> $stable(p_out_en[1]) && $stable(p_dst_en[1]))
    else $error("other port disturbed");
  a_master_local: assert property (p_dst_en[0][DIDX_MASTER] == 1'b0 && p_dst_en[1][DIDX_MASTER] == 1'b0 |=>
    timebase_sel_o == TB_LOCAL) else $error("timebase not local");
  a_start_once: assert property (start_fire_o[0] ##1 !clear_w[0] |-> ##1 !start_fire_o[0])
    else $error("start fired twice");
  a_rx_one_bit: assert property (rx_accept_i[0] && eof_last_bit_i[0] ##1 !eof_last_bit_i[0] |->
    rx_event_o[0] ##1 !rx_event_o[0]) else $error("receive pulse width wrong");
endmodule

// [core/sync_router_pkg.sv]
// Constants for the sync terminal router: terminal codes, status words, register map, timing.
// Assumes a single 125 MHz clock and an APB register port with 32-bit data.
package sync_router_pkg;
  // Structure
  localparam int NUM_PORTS = 2;
  localparam int NUM_LINES = 8;  // General lines 0..6 plus the clock line
  localparam int SEL_W = 4;
  localparam int NUM_DST = 3;
  localparam int ADDR_W = 8;

  // Terminal codes shared by source and destination selectors
  localparam logic [3:0] LAST_GP_LINE = 4'h6;
  localparam logic [3:0] PCCARD_FIRST_GONE = 4'h4;
  localparam logic [3:0] TERM_CLK_LINE = 4'h7;
  localparam logic [3:0] SRC_STAR = 4'h8;
  localparam logic [3:0] SRC_CLK10 = 4'h9;
  localparam logic [3:0] SRC_TB20 = 4'ha;
  localparam logic [3:0] SRC_RESYNC = 4'hb;
  localparam logic [3:0] SRC_RX_EVT = 4'hc;
  localparam logic [3:0] SRC_XCVR_EVT = 4'hd;
  localparam logic [3:0] SRC_START_EVT = 4'he;
  localparam logic [3:0] DST_MASTER_TB = 4'h8;
  localparam logic [3:0] DST_RESYNC = 4'h9;
  localparam logic [3:0] DST_START = 4'ha;
  localparam int DIDX_MASTER = 0;
  localparam int DIDX_RESYNC = 1;
  localparam int DIDX_START = 2;

  // Hardware generation and form factor codes
  localparam logic [1:0] GEN_1 = 2'h1;
  localparam logic [1:0] GEN_2 = 2'h2;
  localparam logic [1:0] GEN_USB = 2'h3;
  localparam logic [1:0] FF_DESKTOP = 2'h0;
  localparam logic [1:0] FF_CHASSIS = 2'h1;
  localparam logic [1:0] FF_PCCARD = 2'h2;

  // Status words, signed
  localparam logic [31:0] ST_OK = 32'h0000_0000;
  localparam logic [31:0] ST_WARN_REPLACED = 32'h0000_0001;
  localparam logic [31:0] ST_ERR_PAIR = 32'hffff_ffff;
  localparam logic [31:0] ST_ERR_UNAVAIL = 32'hffff_fffe;
  localparam logic [31:0] ST_ERR_LIMIT = 32'hffff_fffd;
  localparam logic [31:0] ST_ERR_BUSY = 32'hffff_fffc;

  // Line count limits on first-generation cards
  localparam int HS_IN_MAX = 4;
  localparam int HS_OUT_MAX = 4;
  localparam int LS_IN_MAX = 2;
  localparam int LS_OUT_MAX = 3;

  // Register map
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_RELEASE = 8'h0c;
  localparam logic [7:0] OFF_ROUTE0 = 8'h10;
  localparam logic [7:0] OFF_ROUTE1 = 8'h14;
  localparam logic [7:0] OFF_EVENT = 8'h18;
  localparam int REQ_SRC_LSB = 0;
  localparam int REQ_DST_LSB = 4;
  localparam int REQ_PORT_BIT = 8;
  localparam int CFG_GEN_LSB = 0;
  localparam int CFG_FF_LSB = 2;
  localparam int CFG_LS_BIT = 4;
  localparam logic [1:0] CFG_GEN_RST = GEN_2;
  localparam logic [1:0] CFG_FF_RST = FF_DESKTOP;

  // Master timebase selections
  localparam logic [1:0] TB_LOCAL = 2'h0;
  localparam logic [1:0] TB_CLK_LINE = 2'h1;
  localparam logic [1:0] TB_CLK10 = 2'h2;

  // Timing
  localparam longint CLK_HZ = 125_000_000;
  localparam longint TB20_HZ = 20_000_000;
  localparam longint TB1M_HZ = 1_000_000;
  localparam longint RESYNC_HZ = 10;
  localparam logic [6:0] TB20_HALF = 7'(CLK_HZ / (2 * TB20_HZ));
  localparam logic [6:0] TB1M_HALF = 7'(CLK_HZ / (2 * TB1M_HZ));
  localparam logic [23:0] RESYNC_HALF = 24'(CLK_HZ / (2 * RESYNC_HZ));
endpackage

// [core/port_route_table.sv]
// Routing table of one port: which lines it drives and from what, which lines it reads,
// and which internal destinations it has connected. Requests arrive already checked.
`timescale 1ns/1ps
module port_route_table #(
  parameter int NL = 8,
  parameter int SW = 4,
  parameter int ND = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Checked request
  input wire logic conn_i,
  input wire logic clear_i,
  input wire logic [SW-1:0] src_i,
  input wire logic [SW-1:0] dst_i,
  // Table contents
  output logic [NL-1:0] out_en_o,
  output logic [NL*SW-1:0] out_src_o,
  output logic [NL-1:0] in_mask_o,
  output logic [ND-1:0] dst_en_o,
  output logic [ND*SW-1:0] dst_src_o
);
  typedef struct packed {
    logic [NL-1:0] out_en;
    logic [NL*SW-1:0] out_src;
    logic [NL-1:0] in_mask;
    logic [ND-1:0] dst_en;
    logic [ND*SW-1:0] dst_src;
  } table_s;

  table_s cur_ff;
  table_s nxt_ff;

  // Release wipes the whole port first; a connect then adds exactly one pair
  always_comb begin
    int d;
    int s;
    d = int'(dst_i);
    s = int'(src_i);
    nxt_ff = cur_ff;
    if (clear_i) begin
      nxt_ff = '0;
    end
    if (conn_i) begin
      if (d < NL) begin
        nxt_ff.out_en[d] = 1'b1;
        nxt_ff.out_src[d*SW +: SW] = src_i;
      end else if (d < NL + ND) begin
        nxt_ff.dst_en[d-NL] = 1'b1;
        nxt_ff.dst_src[(d-NL)*SW +: SW] = src_i;
      end
      if (s < NL) begin
        nxt_ff.in_mask[s] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign out_en_o = cur_ff.out_en;
  assign out_src_o = cur_ff.out_src;
  assign in_mask_o = cur_ff.in_mask;
  assign dst_en_o = cur_ff.dst_en;
  assign dst_src_o = cur_ff.dst_src;
endmodule

// [verification/peer_card.sv]
// Peer card on the sync bus: drives general lines 0..6 and leaves the clock line free.
// Assumes the router's line values and enables; works out each wire level.
`timescale 1ns/1ps
module peer_card (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels the peer drives on lines 0..6
  input wire logic [6:0] drive_i,
  // Router side
  input wire logic [7:0] card_val_i,
  input wire logic [7:0] card_oe_i,
  output logic [7:0] line_o
);
  logic idle_ff;
  // The free clock line toggles so a stale level never passes for a driven one
  always_ff @(posedge clk_i) begin
    idle_ff <= rst_i ? 1'b0 : ~idle_ff;
  end
  // Router wins where it drives; lines 0..6 take drive_i, line 7 the toggling idle_ff level
  assign line_o = (card_oe_i & card_val_i) | (~card_oe_i & {idle_ff, drive_i});
endmodule

// [verification/sync_terminal_router_test.sv]
// Self-checking bench for the sync terminal router: matrix sweep and corner cases.
// Assumes the peer card model on the sync bus and APB access from this bench.
`timescale 1ns/1ps
module sync_terminal_router_test;
  import sync_router_pkg::*;
  localparam int HOLD = 16;
  logic clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, serr, qe, prdy, ali, b, tbo;
  logic [7:0] pa = 0, oe, lo, line;
  logic [6:0] pv = 0;
  logic [31:0] pwd = 0, prd, q, seed = 32'h5d82;
  logic [1:0] rxa = 0, eof = 0, fire, rxe, tsel, g, f;
  logic [3:0] s, d;
  int errors = 0, checked = 0, fire_n = 0, ali_n = 0, rx_n = 0, k;
  always #4 clk_i = ~clk_i;
  // Pulse counters for the internal terminal outputs
  always @(posedge clk_i) begin
    fire_n <= fire_n + fire[0];
    ali_n <= ali_n + ali;
    rx_n <= rx_n + rxe[0];
  end
  sync_terminal_router #(.RESYNC_HALF_CYC(24'h8)) sync_terminal_router_i (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(serr), .sync_line_i(line), .sync_line_o(lo), .sync_line_oe_o(oe),
    .star_trigger_connector_pin_i(1'b0), .clk10_i(1'b0), .comm_begin_i(2'b00), .rx_accept_i(rxa), .eof_last_bit_i(eof),
    .xcvr_fault_n_i(2'b11), .start_fire_o(fire), .rx_event_o(rxe), .resync_align_o(ali),
    .timebase_sel_o(tsel), .timebase_out_o(tbo));
  peer_card peer_card_i (.clk_i(clk_i), .rst_i(rst_i), .drive_i(pv), .card_val_i(lo), .card_oe_i(oe),
    .line_o(line));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Refusal expected for a pair on a given generation, form factor and port
  function automatic logic bad(input logic [1:0] g, f, input logic p, input logic [3:0] s, d);
    logic ls, ld, m1, ok, gone;
    ls = s <= LAST_GP_LINE;
    ld = d <= LAST_GP_LINE;
    m1 = ls && (d == DST_RESYNC || d == DST_START) || s == SRC_RESYNC && (ld || d == DST_START)
      || s == SRC_START_EVT && ld;
    ok = g == GEN_1 ? m1 : g == GEN_2 ? m1 || (s == TERM_CLK_LINE || s == SRC_CLK10) && d == DST_MASTER_TB
      || s == SRC_STAR && d == DST_START || s == SRC_TB20 && d == TERM_CLK_LINE
      || s == SRC_RX_EVT && (ld || d == DST_START) || s == SRC_XCVR_EVT && ld && d[0] == p
      : ls && d == DST_START || s == TERM_CLK_LINE && d == DST_MASTER_TB || s == SRC_TB20 && d == TERM_CLK_LINE
      || s == SRC_START_EVT && ld;
    gone = g == GEN_1 ? f == FF_CHASSIS && (s == 4'h6 || d == 4'h6)
      : g == GEN_2 ? f != FF_CHASSIS && (s == SRC_STAR || s == SRC_CLK10) || f == FF_PCCARD
      && (s == SRC_TB20 || ls && s >= PCCARD_FIRST_GONE || ld && d >= PCCARD_FIRST_GONE)
      : ls && s != 4'h0 || ld && d != 4'h0;
    return !ok || gone;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, v);
    end
  endtask
  // Toggles of the exported timebase over four expected half periods
  task automatic tb_rate(input int h);
    int n;
    n = 0;
    b = tbo;
    repeat (4 * h) begin
      @(posedge clk_i);
      n += int'(tbo !== b);
      b = tbo;
    end
    chk("timebase toggles", 32'h4, 32'(n));
  endtask
  // One APB transfer; a clock edge passes after release so transfers never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= dv;
    @(posedge clk_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      wrap_up();
    end
    q = prd;
    qe = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask
  // Connect request followed by a status read into q
  task automatic req(input logic p, input logic [3:0] sv, input logic [3:0] dv);
    apb(1'b1, OFF_REQ, 32'({p, dv, sv}));
    apb(1'b0, OFF_STATUS, 32'h0);
  endtask
  // Two rising edges on one line, each level held long enough for slow receivers
  task automatic pulse(input int ln);
    repeat (2) begin
      pv[ln] <= 1'b1;
      repeat (HOLD) @(posedge clk_i);
      pv[ln] <= 1'b0;
      repeat (HOLD) @(posedge clk_i);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, OFF_CFG, 32'h0);
    chk("cfg reset", 32'({FF_DESKTOP, GEN_2}), q);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], qe});
    // Every pair on every generation, with random form factor and port
    for (int i = 0; i < 495; i++) begin
      seed = lfsr(seed);
      g = 2'(i / 165) + 2'h1;
      f = 2'(seed % 3);
      s = 4'((i / 11) % 15);
      d = 4'(i % 11);
      b = bad(g, f, seed[8], s, d);
      apb(1'b1, OFF_CFG, 32'({f, g}));
      req(seed[8], s, d);
      chk("status", 32'(b), q === ST_OK ? 32'h0 : (q[31] === 1'b1 ? 32'h1 : 32'h2));
      apb(1'b0, seed[8] ? OFF_ROUTE1 : OFF_ROUTE0, 32'h0);
      chk("route after refusal", 32'h0, b ? q : 32'h0);
      apb(1'b1, OFF_RELEASE, 32'h3);
    end
    $display("matrix sweep done");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CFG, 32'({k[0], FF_DESKTOP, GEN_1}));
      for (int i = 0; i <= (k ? LS_IN_MAX : HS_IN_MAX); i++) begin
        req(1'b0, 4'(i), DST_START);
        chk("in limit", i == 0 ? ST_OK : i == (k ? LS_IN_MAX : HS_IN_MAX) ? ST_ERR_LIMIT : ST_WARN_REPLACED, q);
      end
      apb(1'b1, OFF_RELEASE, 32'h3);
      for (int i = 0; i <= (k ? LS_OUT_MAX : HS_OUT_MAX); i++) begin
        req(1'b0, SRC_RESYNC, 4'(i));
        chk("out limit", i == (k ? LS_OUT_MAX : HS_OUT_MAX) ? ST_ERR_LIMIT : ST_OK, q);
      end
      apb(1'b1, OFF_RELEASE, 32'h3);
    end
    $display("line limits done");
    apb(1'b1, OFF_CFG, 32'({FF_CHASSIS, GEN_2}));
    req(1'b0, SRC_START_EVT, 4'h0);
    req(1'b1, SRC_START_EVT, 4'h1);
    apb(1'b1, OFF_RELEASE, 32'h1);
    apb(1'b0, OFF_ROUTE0, 32'h0);
    chk("route0 released", 32'h0, q);
    apb(1'b0, OFF_ROUTE1, 32'h0);
    chk("route1 kept", 32'h2, q);
    repeat (3) @(posedge clk_i);
    chk("line enables", 32'h2, 32'(oe));
    req(1'b0, 4'h3, DST_START);
    k = fire_n;
    pulse(3);
    chk("start once", 32'(k + 1), 32'(fire_n));
    req(1'b0, SRC_START_EVT, 4'h5);
    chk("start event line", 32'h1, 32'(lo[5]));
    req(1'b0, 4'h2, DST_RESYNC);
    k = ali_n;
    pulse(2);
    chk("resync edges", 32'(k + 2), 32'(ali_n));
    k = rx_n;
    rxa <= 2'b01;
    eof <= 2'b01;
    @(posedge clk_i);
    eof <= 2'b00;
    repeat (3) @(posedge clk_i);
    rxa <= 2'b00;
    repeat (3) @(posedge clk_i);
    chk("receive pulse", 32'(k + 1), 32'(rx_n));
    req(1'b0, TERM_CLK_LINE, DST_MASTER_TB);
    repeat (3) @(posedge clk_i);
    chk("timebase line", 32'(TB_CLK_LINE), 32'(tsel));
    req(1'b0, SRC_CLK10, DST_MASTER_TB);
    chk("timebase clk10", 32'(TB_CLK10), 32'(tsel));
    apb(1'b1, OFF_RELEASE, 32'h3);
    repeat (3) @(posedge clk_i);
    chk("timebase local", 32'(TB_LOCAL), 32'(tsel));
    tb_rate(TB20_HALF);
    apb(1'b1, OFF_CFG, 32'({FF_DESKTOP, GEN_USB}));
    tb_rate(TB1M_HALF);
    $display("terminal events done");
    wrap_up();
  end
endmodule
